// ===== core/hcr_ctrl_regs.sv
`timescale 1ns/100ps
`default_nettype none
module hcr_ctrl_regs (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire hcr_pkg::hcr_req_t req_i,
	input wire logic [15:0] pin_level_i,
	input wire hcr_pkg::hcr_edge_sel_t edge_sel_i,
	input wire logic config_done_i,
	input wire logic pin_takeover_pending_i,
	input wire logic [6:0] strap_address_i,
	input wire logic fused_address_use_flag_i,
	input wire logic [6:0] fused_target_address_i,
	input wire logic downstream_facing_role_i,
	input wire logic upstream_facing_role_i,
	output logic [7:0] rdata_o,
	output logic broadcast_address_enable_o,
	output logic one_megahertz_mode_enable_o,
	output logic [6:0] target_address_o,
	output logic staged_pin_config_apply_o,
	output logic software_chip_reset_o,
	output logic pin_event_irq_o,
	output logic ready_irq_o,
	output logic [6:0] alt_function_sel_o
);
	typedef struct packed {
		logic [7:0] rdata;
		logic bcast;
		logic fmp;
		logic ready;
		logic apply;
		logic apply_strobe;
		logic software_chip_reset;
		logic [6:0] taddr;
		logic addr_load;
		logic [15:0] sync1;
		logic [15:0] sync2;
		logic [15:0] prev;
		logic [15:0] sts;
		logic [15:0] en;
		logic irq;
		logic ready_irq;
		logic [6:0] alt_sel;
	} hcr_state_t;

	hcr_state_t st;
	hcr_state_t next_st;
	logic [15:0] evt;
	logic [15:0] gp_mask;
	logic role_alt;

	// edge detect on the second synchroniser flop only, never on the first
	assign role_alt = downstream_facing_role_i | upstream_facing_role_i;
	assign evt = ((st.sync2 & ~st.prev & edge_sel_i.rise_en)
		| (~st.sync2 & st.prev & edge_sel_i.fall_en)) & gp_mask;

	// dedicated pins drop out of general purpose event detection
	genvar gi;
	generate
		for (gi = 0; gi < hcr_pkg::PIN_COUNT; gi++) begin : g_mask
			if (gi >= hcr_pkg::ALT_FIRST_PIN) begin : g_alt
				assign gp_mask[gi] = ~role_alt;
			end else begin : g_gp
				assign gp_mask[gi] = 1'b1;
			end
		end
	endgenerate

	// next state of the whole bank
	always_comb begin
		logic [15:0] clr;
		clr = 16'h0000;
		next_st = st;
		next_st.sync1 = pin_level_i;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		next_st.apply_strobe = 1'b0;
		next_st.software_chip_reset = 1'b0;
		next_st.addr_load = 1'b0;
		next_st.alt_sel = role_alt ? 7'h7F : 7'h00;
		// ready is sticky until the next system reset
		if (config_done_i) begin
			next_st.ready = 1'b1;
		end
		// address comes from strap or fuses one cycle after reset release
		if (st.addr_load) begin
			next_st.taddr = fused_address_use_flag_i ? fused_target_address_i : strap_address_i;
		end
		// hold the apply request while a takeover is pending
		if (st.apply && !pin_takeover_pending_i) begin
			next_st.apply = 1'b0;
			next_st.apply_strobe = 1'b1;
		end
		if (req_i.wr) begin
			case (req_i.addr)
				hcr_pkg::HW_CTRL_LO_OFS: begin
					next_st.bcast = req_i.wdata[hcr_pkg::BCAST_BIT];
					next_st.fmp = req_i.wdata[hcr_pkg::FMP_BIT];
					if (req_i.wdata[hcr_pkg::APPLY_BIT]) begin
						next_st.apply = 1'b1;
					end
					next_st.software_chip_reset = req_i.wdata[hcr_pkg::SOFTWARE_CHIP_RESET_BIT];
				end
				hcr_pkg::TARGET_ADDR_OFS: begin
					next_st.taddr = req_i.wdata[6:0];
				end
				hcr_pkg::EVT_STS_LO_OFS: begin
					clr[7:0] = req_i.wdata;
				end
				hcr_pkg::EVT_STS_HI_OFS: begin
					clr[15:8] = req_i.wdata;
				end
				hcr_pkg::EVT_EN_LO_OFS: begin
					next_st.en[7:0] = req_i.wdata;
				end
				hcr_pkg::EVT_EN_HI_OFS: begin
					next_st.en[15:8] = req_i.wdata;
				end
				default: begin
				end
			endcase
		end
		// a new edge wins over a clear in the same cycle
		next_st.sts = (st.sts & ~clr) | evt;
		next_st.irq = |(next_st.sts & next_st.en);
		next_st.ready_irq = next_st.ready;
		// read data is registered; unmapped bytes read zero
		if (req_i.rd) begin
			case (req_i.addr)
				hcr_pkg::HW_CTRL_LO_OFS: begin
					next_st.rdata = {2'b00, st.bcast, 1'b0, st.fmp, st.ready, st.apply, 1'b0};
				end
				hcr_pkg::TARGET_ADDR_OFS: begin
					next_st.rdata = {1'b0, st.taddr};
				end
				hcr_pkg::LEVEL_LO_OFS: begin
					next_st.rdata = st.sync2[7:0];
				end
				hcr_pkg::LEVEL_HI_OFS: begin
					next_st.rdata = st.sync2[15:8];
				end
				hcr_pkg::EVT_STS_LO_OFS: begin
					next_st.rdata = st.sts[7:0];
				end
				hcr_pkg::EVT_STS_HI_OFS: begin
					next_st.rdata = st.sts[15:8];
				end
				hcr_pkg::EVT_EN_LO_OFS: begin
					next_st.rdata = st.en[7:0];
				end
				hcr_pkg::EVT_EN_HI_OFS: begin
					next_st.rdata = st.en[15:8];
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
	end

	// synchronous reset; address is loaded by a clocked step after release
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.bcast <= hcr_pkg::BCAST_RST;
			st.fmp <= hcr_pkg::FMP_RST;
			st.addr_load <= 1'b1;
			st.sts <= hcr_pkg::EVT_STS_RST;
			st.en <= hcr_pkg::EVT_EN_RST;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign broadcast_address_enable_o = st.bcast;
	assign one_megahertz_mode_enable_o = st.fmp;
	assign target_address_o = st.taddr;
	assign staged_pin_config_apply_o = st.apply_strobe;
	assign software_chip_reset_o = st.software_chip_reset;
	assign pin_event_irq_o = st.irq;
	assign ready_irq_o = st.ready_irq;
	assign alt_function_sel_o = st.alt_sel;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_hw_write(int b);
		req_i.wr && req_i.addr == hcr_pkg::HW_CTRL_LO_OFS && req_i.wdata[b];
	endsequence

	property p_ctrl_reset;
		@(posedge core_clk_i) $past(sys_rst_i) && !sys_rst_i |-> !broadcast_address_enable_o && one_megahertz_mode_enable_o;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control bits wrong after reset");

	property p_ready_set;
		config_done_i |=> st.ready ##1 ready_irq_o;
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("ready flag not raised");

	// a fresh apply write in the cycle the held request is released re-arms the bit, so leave that case out
	property p_apply_go;
		st.apply && !pin_takeover_pending_i
			&& !(req_i.wr && req_i.addr == hcr_pkg::HW_CTRL_LO_OFS && req_i.wdata[hcr_pkg::APPLY_BIT])
			|=> staged_pin_config_apply_o && !st.apply ##1 !staged_pin_config_apply_o;
	endproperty
	a_apply_go: assert property (p_apply_go) else $error("apply not carried out");

	property p_apply_hold;
		st.apply && pin_takeover_pending_i |=> !staged_pin_config_apply_o && st.apply;
	endproperty
	a_apply_hold: assert property (p_apply_hold) else $error("apply acted while takeover pending");

	property p_software_chip_reset;
		s_hw_write(hcr_pkg::SOFTWARE_CHIP_RESET_BIT) |=> software_chip_reset_o ##1 !software_chip_reset_o;
	endproperty
	a_software_chip_reset: assert property (p_software_chip_reset) else $error("software reset pulse wrong");

	property p_addr_load;
		st.addr_load |=> target_address_o == ($past(fused_address_use_flag_i) ?
			$past(fused_target_address_i) : $past(strap_address_i));
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("target address not loaded");

	property p_event_set;
		evt != 16'h0000 |=> (st.sts & $past(evt)) == $past(evt);
	endproperty
	a_event_set: assert property (p_event_set) else $error("edge did not set event status");

	property p_event_clear;
		req_i.wr && req_i.addr == hcr_pkg::EVT_STS_LO_OFS && evt[7:0] == 8'h00
			|=> st.sts[7:0] == ($past(st.sts[7:0]) & ~$past(req_i.wdata));
	endproperty
	a_event_clear: assert property (p_event_clear) else $error("event clear wrong");

	property p_irq;
		pin_event_irq_o == |(st.sts & st.en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq does not match enabled events");

	property p_level_read;
		req_i.rd && req_i.addr == hcr_pkg::LEVEL_LO_OFS |=> rdata_o == $past(st.sync2[7:0]);
	endproperty
	a_level_read: assert property (p_level_read) else $error("level read wrong");

	property p_level_read_hi;
		req_i.rd && req_i.addr == hcr_pkg::LEVEL_HI_OFS |=> rdata_o == $past(st.sync2[15:8]);
	endproperty
	a_level_read_hi: assert property (p_level_read_hi) else $error("upper level read wrong");

	// register writes land one edge after the request is taken
	property p_taddr_write;
		req_i.wr && req_i.addr == hcr_pkg::TARGET_ADDR_OFS |=> target_address_o == $past(req_i.wdata[6:0]);
	endproperty
	a_taddr_write: assert property (p_taddr_write) else $error("target address write lost");

	property p_ctrl_write;
		req_i.wr && req_i.addr == hcr_pkg::HW_CTRL_LO_OFS
			|=> broadcast_address_enable_o == $past(req_i.wdata[hcr_pkg::BCAST_BIT])
			&& one_megahertz_mode_enable_o == $past(req_i.wdata[hcr_pkg::FMP_BIT]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control bit write lost");

	property p_en_write_lo;
		req_i.wr && req_i.addr == hcr_pkg::EVT_EN_LO_OFS |=> st.en[7:0] == $past(req_i.wdata);
	endproperty
	a_en_write_lo: assert property (p_en_write_lo) else $error("low enable write lost");

	property p_en_write_hi;
		req_i.wr && req_i.addr == hcr_pkg::EVT_EN_HI_OFS |=> st.en[15:8] == $past(req_i.wdata);
	endproperty
	a_en_write_hi: assert property (p_en_write_hi) else $error("high enable write lost");

	property p_event_clear_hi;
		req_i.wr && req_i.addr == hcr_pkg::EVT_STS_HI_OFS && evt[15:8] == 8'h00
			|=> st.sts[15:8] == ($past(st.sts[15:8]) & ~$past(req_i.wdata));
	endproperty
	a_event_clear_hi: assert property (p_event_clear_hi) else $error("upper event clear wrong");

	// dedicated pins: select lines all high and no new event bits
	property p_alt_sel;
		role_alt |=> alt_function_sel_o == 7'h7F;
	endproperty
	a_alt_sel: assert property (p_alt_sel) else $error("dedicated pin select missing");

	property p_alt_quiet;
		role_alt |=> (st.sts[15:9] & ~$past(st.sts[15:9])) == 7'h00;
	endproperty
	a_alt_quiet: assert property (p_alt_quiet) else $error("dedicated pin raised an event");

	property p_no_select;
		edge_sel_i == 32'h00000000 |=> (st.sts & ~$past(st.sts)) == 16'h0000;
	endproperty
	a_no_select: assert property (p_no_select) else $error("event without edge select");

	// two quiet cycles after reset before the pipeline mirrors the pins
	property p_sync;
		!$past(sys_rst_i) && !$past(sys_rst_i, 2)
			|-> st.sync2 == $past(pin_level_i, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("level pipeline depth wrong");

	property p_ready_sticky;
		st.ready |=> st.ready;
	endproperty
	a_ready_sticky: assert property (p_ready_sticky) else $error("ready flag dropped");

	property p_irq_hold;
		pin_event_irq_o && !(req_i.wr && req_i.addr[7:2] == hcr_pkg::EVT_STS_LO_OFS[7:2])
			&& !(req_i.wr && req_i.addr == hcr_pkg::EVT_EN_LO_OFS)
			&& !(req_i.wr && req_i.addr == hcr_pkg::EVT_EN_HI_OFS)
			|=> pin_event_irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a clear");

	property p_apply_source;
		staged_pin_config_apply_o |-> $past(st.apply) && !$past(pin_takeover_pending_i);
	endproperty
	a_apply_source: assert property (p_apply_source) else $error("apply strobe without request");

	property p_software_chip_reset_source;
		software_chip_reset_o
			|-> $past(req_i.wr && req_i.addr == hcr_pkg::HW_CTRL_LO_OFS && req_i.wdata[hcr_pkg::SOFTWARE_CHIP_RESET_BIT]);
	endproperty
	a_software_chip_reset_source: assert property (p_software_chip_reset_source) else $error("chip reset pulse without write");
endmodule : hcr_ctrl_regs
`default_nettype wire

// ===== core/hcr_pkg.sv
package hcr_pkg;
	// byte offsets of the register bank
	localparam logic [7:0] HW_CTRL_LO_OFS = 8'h18;
	localparam logic [7:0] HW_CTRL_HI_OFS = 8'h19;
	localparam logic [7:0] TARGET_ADDR_OFS = 8'h1A;
	localparam logic [7:0] LEVEL_LO_OFS = 8'h20;
	localparam logic [7:0] LEVEL_HI_OFS = 8'h21;
	localparam logic [7:0] EVT_STS_LO_OFS = 8'h22;
	localparam logic [7:0] EVT_STS_HI_OFS = 8'h23;
	localparam logic [7:0] EVT_EN_LO_OFS = 8'h24;
	localparam logic [7:0] EVT_EN_HI_OFS = 8'h25;

	// hardware_control field positions
	localparam int BCAST_BIT = 5;
	localparam int FMP_BIT = 3;
	localparam int READY_BIT = 2;
	localparam int APPLY_BIT = 1;
	localparam int SOFTWARE_CHIP_RESET_BIT = 0;

	// values after reset
	localparam logic BCAST_RST = 1'b0;
	localparam logic FMP_RST = 1'b1;
	localparam logic [15:0] EVT_STS_RST = 16'h0000;
	localparam logic [15:0] EVT_EN_RST = 16'h0000;

	// pins that carry dedicated functions in the standalone roles
	localparam int ALT_FIRST_PIN = 9;
	localparam int ALT_PIN_COUNT = 7;
	localparam int PIN_COUNT = 16;

	// register access request from the serial port front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hcr_req_t;

	// per-pin edge selection taken from the live pin configuration
	typedef struct packed {
		logic [15:0] rise_en;
		logic [15:0] fall_en;
	} hcr_edge_sel_t;
endpackage : hcr_pkg

// ===== tb/hcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the byte register port
module hcr_host_model (
	input wire logic core_clk_i,
	input wire logic [7:0] rdata_i,
	output var hcr_pkg::hcr_req_t req_o,
	output var logic takeover_o
);
	initial begin
		req_o = '0;
		takeover_o = 1'b0;
	end
	// one access, request held for exactly the taking edge
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rd);
		@(posedge core_clk_i);
		req_o <= {wr, ~wr, addr, wdata};
		@(posedge core_clk_i);
		req_o <= '0;
		#1 rd = rdata_i;
	endtask : xfer
	// software raises or drops the takeover pending level; dropping it lets a held apply go
	task automatic set_takeover(input logic v);
		@(posedge core_clk_i);
		takeover_o <= v;
	endtask : set_takeover
endmodule : hcr_host_model
`default_nettype wire

// ===== tb/hw_control_and_pio_status_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module hw_control_and_pio_status_regs_tb_top;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [15:0] pins = '0;
	hcr_pkg::hcr_edge_sel_t esel = '0;
	logic cfg_done = 1'b0, downstream_facing_role = 1'b0, upstream_facing_role = 1'b0, fflag = 1'b0;
	logic [6:0] strap = 7'h2A, faddr = 7'h61;
	hcr_pkg::hcr_req_t req;
	logic tk, bc, fmp, apply, srst, irq, rdy_irq;
	logic [7:0] rdata, rd;
	logic [6:0] taddr, alt;
	int bad_count = 0, cmp_count = 0, cyc = 0, n_apply = 0, n_rst = 0;
	always #50 core_clk_i = ~core_clk_i;
	hcr_host_model u_hcr_host_model (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req), .takeover_o(tk));
	hcr_ctrl_regs u_hcr_ctrl_regs (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .pin_level_i(pins),
		.edge_sel_i(esel), .config_done_i(cfg_done), .pin_takeover_pending_i(tk), .strap_address_i(strap),
		.fused_address_use_flag_i(fflag), .fused_target_address_i(faddr), .downstream_facing_role_i(downstream_facing_role),
		.upstream_facing_role_i(upstream_facing_role), .rdata_o(rdata), .broadcast_address_enable_o(bc),
		.one_megahertz_mode_enable_o(fmp), .target_address_o(taddr), .staged_pin_config_apply_o(apply),
		.software_chip_reset_o(srst), .pin_event_irq_o(irq), .ready_irq_o(rdy_irq), .alt_function_sel_o(alt));
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		u_hcr_host_model.xfer(1'b0, a, 8'h00, rd);
		chk(rd, exp);
	endtask : rdc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_hcr_host_model.xfer(1'b1, a, d, rd);
	endtask : wr
	// pulses are one cycle wide, so count them at every edge; a hang ends the run
	always @(posedge core_clk_i) begin
		cyc++;
		if (apply === 1'b1) n_apply++;
		if (srst === 1'b1) n_rst++;
		if (cyc > 3000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic t_reset_and_addr;
		rdc(hcr_pkg::HW_CTRL_LO_OFS, 8'h08);
		rdc(hcr_pkg::EVT_STS_LO_OFS, 8'h00);
		rdc(hcr_pkg::EVT_EN_HI_OFS, 8'h00);
		chk(taddr, strap);
		wr(hcr_pkg::TARGET_ADDR_OFS, 8'hD5);
		rdc(hcr_pkg::TARGET_ADDR_OFS, 8'h55);
		chk(taddr, 7'h55);
		rdc(8'h30, 8'h00);
		wr(hcr_pkg::HW_CTRL_LO_OFS, 8'h20);
		chk(bc, 1'b1);
		chk(fmp, 1'b0);
	endtask : t_reset_and_addr
	// apply held back by a pending takeover, then released
	task automatic t_apply_and_software_chip_reset;
		u_hcr_host_model.set_takeover(1'b1);
		wr(hcr_pkg::HW_CTRL_LO_OFS, 8'h2A);
		repeat (4) @(posedge core_clk_i);
		chk(16'(n_apply), 16'h0000);
		rdc(hcr_pkg::HW_CTRL_LO_OFS, 8'h2A);
		u_hcr_host_model.set_takeover(1'b0);
		repeat (4) @(posedge core_clk_i);
		chk(16'(n_apply), 16'h0001);
		rdc(hcr_pkg::HW_CTRL_LO_OFS, 8'h28);
		wr(hcr_pkg::HW_CTRL_LO_OFS, 8'h29);
		repeat (3) @(posedge core_clk_i);
		chk(16'(n_rst), 16'h0001);
		rdc(hcr_pkg::HW_CTRL_LO_OFS, 8'h28);
	endtask : t_apply_and_software_chip_reset
	task automatic t_events;
		@(posedge core_clk_i);
		esel.rise_en <= 16'h0001;
		pins <= 16'h0001;
		repeat (5) @(posedge core_clk_i);
		rdc(hcr_pkg::LEVEL_LO_OFS, 8'h01);
		rdc(hcr_pkg::EVT_STS_LO_OFS, 8'h01);
		chk(irq, 1'b0);
		wr(hcr_pkg::EVT_EN_LO_OFS, 8'h01);
		#200 chk(irq, 1'b1);
		wr(hcr_pkg::EVT_STS_LO_OFS, 8'h00);
		rdc(hcr_pkg::EVT_STS_LO_OFS, 8'h01);
		wr(hcr_pkg::EVT_STS_LO_OFS, 8'h01);
		#200 chk(irq, 1'b0);
		rdc(hcr_pkg::EVT_STS_LO_OFS, 8'h00);
		@(posedge core_clk_i);
		esel.fall_en <= 16'h0001;
		pins <= 16'h0000;
		repeat (5) @(posedge core_clk_i);
		rdc(hcr_pkg::EVT_STS_LO_OFS, 8'h01);
	endtask : t_events
	task automatic t_ready_roles_fused;
		@(posedge core_clk_i);
		cfg_done <= 1'b1;
		downstream_facing_role <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		rdc(hcr_pkg::HW_CTRL_LO_OFS, 8'h2C);
		chk(rdy_irq, 1'b1);
		chk(alt, 7'h7F);
		// pin 9 is dedicated while the role is up, pin 1 still reports
		@(posedge core_clk_i);
		esel.rise_en <= 16'h0202;
		pins <= 16'h0202;
		repeat (5) @(posedge core_clk_i);
		rdc(hcr_pkg::LEVEL_HI_OFS, 8'h02);
		rdc(hcr_pkg::EVT_STS_HI_OFS, 8'h00);
		rdc(hcr_pkg::EVT_STS_LO_OFS, 8'h03);
		@(posedge core_clk_i);
		fflag <= 1'b1;
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		chk(taddr, faddr);
	endtask : t_ready_roles_fused
	initial begin
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		t_reset_and_addr();
		t_apply_and_software_chip_reset();
		t_events();
		t_ready_roles_fused();
		close_out();
	end
endmodule : hw_control_and_pio_status_regs_tb_top
`default_nettype wire
